// File: pkg/lbx_pkg.sv
// constants, opcodes and state type of the ladder bit logic executor
package lbx_pkg;
  // program memory shape
  localparam int PROG_AW = 15;
  localparam int PROG_DW = 16;
  localparam logic [PROG_AW-1:0] START_ADDR = 15'h0000;
  // instruction word fields
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 12;
  localparam int OPND_MSB = 11;
  localparam int OPND_LSB = 0;
  localparam int EXT_MSB = 1;
  localparam int EXT_LSB = 0;
  // bit area shape
  localparam int BIT_AW = 12;
  // save buffer: eight blocks loaded means seven saved conditions
  localparam int STACK_DEPTH = 7;
  localparam int SP_W = 3;
  localparam logic [SP_W-1:0] SP_FULL = 3'h7;
  localparam logic [SP_W-1:0] SP_EMPTY = 3'h0;
  localparam logic [SP_W-1:0] SP_ONE = 3'h1;
  // word counts
  localparam logic [PROG_AW:0] LEN_ONE = 16'h0001;
  // opcodes
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_LOAD_INV = 4'h2;
  localparam logic [3:0] OP_AND = 4'h3;
  localparam logic [3:0] OP_AND_INV = 4'h4;
  localparam logic [3:0] OP_OR = 4'h5;
  localparam logic [3:0] OP_OR_INV = 4'h6;
  localparam logic [3:0] OP_BLOCK_AND = 4'h7;
  localparam logic [3:0] OP_BLOCK_OR = 4'h8;
  localparam logic [3:0] OP_OUT = 4'h9;
  localparam logic [3:0] OP_OUT_INV = 4'hA;
  localparam logic [3:0] OP_OTHER = 4'hE;
  localparam logic [3:0] OP_END = 4'hF;
  // controller states
  typedef enum logic [2:0] {
    S_FIND = 3'h0,
    S_FIND_CHK = 3'h1,
    S_FETCH = 3'h2,
    S_DECODE = 3'h3,
    S_BITRD = 3'h4,
    S_EXEC = 3'h5,
    S_HALT = 3'h6
  } lbx_state_t;
endpackage : lbx_pkg

// File: rtl/lbx_ladder_bit_logic_executor.sv
// bit logic execution unit: fetch, decode and evaluate ladder instructions
//
// Behaviour
// - line-start load sets condition to operand bit; inverted load to its complement.
// - fetch starts at address 00000; one instruction spans one to four words.
// - series and parallel instructions combine condition with operand bit.
// - inverted series ANDs condition with complement of operand bit.
// - inverted parallel ORs condition with complement of operand bit.
// - direct output writes operand bit equal to the condition.
// - inverted output writes operand bit as complement of the condition.
// - each output instruction is one word, its only operand the target bit.
// - scan runs to first end, then restarts; later instructions never execute.
// - end takes no operand and no condition may share its line.
// - without any end instruction in the program, nothing is executed.
// - mid-line load pushes the condition, then restarts from its operand.
// - a saved condition arises only from a load that is not line-first.
// - block_and ANDs condition with newest saved entry and consumes it.
// - block_or is like block_and but ORs.
// - block instructions have no operands; they use saved conditions only.
// - save buffer holds seven entries, enough for eight loaded blocks.
`timescale 1ns/1ps
module lbx_ladder_bit_logic_executor (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // program memory, synchronous read with one cycle latency
  output logic [lbx_pkg::PROG_AW-1:0] prog_addr,
  output logic prog_rd_en,
  input wire logic [lbx_pkg::PROG_DW-1:0] prog_rdata,
  // io_relay_area bit access, synchronous read with one cycle latency
  output logic [lbx_pkg::BIT_AW-1:0] bit_addr,
  output logic bit_rd_en,
  input wire logic bit_rdata,
  output logic bit_wr_en,
  output logic bit_wdata,
  // status
  output logic exec_cond,
  output logic scan_done,
  output logic running,
  output logic no_end_halt,
  output logic fault_overflow,
  output logic fault_underflow,
  output logic fault_end_cond
);

  localparam int STACK_TOP = lbx_pkg::STACK_DEPTH - 1;

  lbx_pkg::lbx_state_t state_q;
  lbx_pkg::lbx_state_t state_d;
  logic [lbx_pkg::PROG_AW-1:0] addr_q;
  logic [3:0] op_q;
  logic cond_q;
  logic line_q;
  logic [lbx_pkg::SP_W-1:0] sp_q;
  logic [STACK_TOP:0] stk_q;
  logic [lbx_pkg::BIT_AW-1:0] bit_addr_q;
  logic bit_we_q;
  logic bit_wd_q;
  logic done_q;
  logic halt_q;
  logic ovf_q;
  logic unf_q;
  logic endc_q;

  // instruction word fields
  logic [3:0] op;
  logic [lbx_pkg::BIT_AW-1:0] opnd;
  logic [lbx_pkg::PROG_AW:0] len;
  logic [lbx_pkg::PROG_AW:0] next_sum;
  logic wrap;
  logic [lbx_pkg::PROG_AW-1:0] next_addr;
  logic [lbx_pkg::PROG_AW-1:0] next_one;

  assign op = prog_rdata[lbx_pkg::OP_MSB:lbx_pkg::OP_LSB];
  assign opnd = prog_rdata[lbx_pkg::OPND_MSB:lbx_pkg::OPND_LSB];

  // word count of the fetched instruction
  always_comb begin
    if (op == lbx_pkg::OP_OTHER) begin
      len = lbx_pkg::LEN_ONE + {14'h0000, prog_rdata[lbx_pkg::EXT_MSB:lbx_pkg::EXT_LSB]};
    end else begin
      len = lbx_pkg::LEN_ONE;
    end
  end

  assign next_sum = {1'b0, addr_q} + len;
  assign wrap = next_sum[lbx_pkg::PROG_AW];
  assign next_addr = next_sum[lbx_pkg::PROG_AW-1:0];
  assign next_one = addr_q + 15'h0001;

  // decode classes
  logic is_cond;
  logic is_load;
  logic is_block;
  logic is_out;
  logic exec_load;
  logic stack_top_val;
  logic bit_val;

  assign is_cond = (op >= lbx_pkg::OP_LOAD) && (op <= lbx_pkg::OP_OR_INV);
  assign is_block = (op == lbx_pkg::OP_BLOCK_AND) || (op == lbx_pkg::OP_BLOCK_OR);
  assign is_out = (op == lbx_pkg::OP_OUT) || (op == lbx_pkg::OP_OUT_INV);
  assign is_load = (op_q == lbx_pkg::OP_LOAD) || (op_q == lbx_pkg::OP_LOAD_INV);
  assign exec_load = (state_q == lbx_pkg::S_EXEC) && is_load;
  assign stack_top_val = (sp_q == lbx_pkg::SP_EMPTY) ? 1'b0 : stk_q[sp_q - lbx_pkg::SP_ONE];
  assign bit_val = bit_rdata;

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      lbx_pkg::S_FIND: begin
        state_d = lbx_pkg::S_FIND_CHK;
      end
      lbx_pkg::S_FIND_CHK: begin
        if (op == lbx_pkg::OP_END) begin
          state_d = lbx_pkg::S_FETCH;
        end else if (wrap) begin
          state_d = lbx_pkg::S_HALT;
        end else begin
          state_d = lbx_pkg::S_FIND;
        end
      end
      lbx_pkg::S_FETCH: begin
        state_d = lbx_pkg::S_DECODE;
      end
      lbx_pkg::S_DECODE: begin
        if (is_cond) begin
          state_d = lbx_pkg::S_BITRD;
        end else begin
          state_d = lbx_pkg::S_FETCH;
        end
      end
      lbx_pkg::S_BITRD: begin
        state_d = lbx_pkg::S_EXEC;
      end
      lbx_pkg::S_EXEC: begin
        state_d = lbx_pkg::S_FETCH;
      end
      lbx_pkg::S_HALT: begin
        state_d = lbx_pkg::S_HALT;
      end
      default: begin
        state_d = lbx_pkg::S_HALT;
      end
    endcase
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q <= lbx_pkg::S_FIND;
    end else begin
      state_q <= state_d;
    end
  end

  // program address: search pass, then scan from the start
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      addr_q <= lbx_pkg::START_ADDR;
    end else if (state_q == lbx_pkg::S_FIND_CHK) begin
      if (op == lbx_pkg::OP_END) begin
        addr_q <= lbx_pkg::START_ADDR;
      end else if (!wrap) begin
        addr_q <= next_addr;
      end
    end else if (state_q == lbx_pkg::S_DECODE) begin
      if (op == lbx_pkg::OP_END) begin
        addr_q <= lbx_pkg::START_ADDR;
      end else if (!is_cond) begin
        addr_q <= next_addr;
      end
    end else if (state_q == lbx_pkg::S_EXEC) begin
      addr_q <= next_one;
    end
  end

  // latched opcode of the condition waiting for its bit
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      op_q <= lbx_pkg::OP_NOP;
    end else if ((state_q == lbx_pkg::S_DECODE) && is_cond) begin
      op_q <= op;
    end
  end

  // execution condition
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cond_q <= 1'b0;
    end else if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_END)) begin
      cond_q <= 1'b0;
    end else if ((state_q == lbx_pkg::S_DECODE) && is_block) begin
      if (op == lbx_pkg::OP_BLOCK_AND) begin
        cond_q <= cond_q & stack_top_val;
      end else begin
        cond_q <= cond_q | stack_top_val;
      end
    end else if (state_q == lbx_pkg::S_EXEC) begin
      case (op_q)
        lbx_pkg::OP_LOAD: cond_q <= bit_val;
        lbx_pkg::OP_LOAD_INV: cond_q <= ~bit_val;
        lbx_pkg::OP_AND: cond_q <= cond_q & bit_val;
        lbx_pkg::OP_AND_INV: cond_q <= cond_q & ~bit_val;
        lbx_pkg::OP_OR: cond_q <= cond_q | bit_val;
        lbx_pkg::OP_OR_INV: cond_q <= cond_q | ~bit_val;
        default: cond_q <= cond_q;
      endcase
    end
  end

  // instruction line in progress: a load seen now is not line-first
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      line_q <= 1'b0;
    end else if (state_q == lbx_pkg::S_DECODE) begin
      if (is_out || (op == lbx_pkg::OP_END)) begin
        line_q <= 1'b0;
      end
    end else if (state_q == lbx_pkg::S_EXEC) begin
      line_q <= 1'b1;
    end
  end

  // save buffer pointer
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sp_q <= lbx_pkg::SP_EMPTY;
    end else if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_END)) begin
      sp_q <= lbx_pkg::SP_EMPTY;
    end else if ((state_q == lbx_pkg::S_DECODE) && is_block) begin
      if (sp_q != lbx_pkg::SP_EMPTY) begin
        sp_q <= sp_q - lbx_pkg::SP_ONE;
      end
    end else if (exec_load && line_q && (sp_q != lbx_pkg::SP_FULL)) begin
      sp_q <= sp_q + lbx_pkg::SP_ONE;
    end
  end

  // save buffer entries, one per generate step
  genvar gi;
  generate
    for (gi = 0; gi < lbx_pkg::STACK_DEPTH; gi++) begin : g_stk
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          stk_q[gi] <= 1'b0;
        end else if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_END)) begin
          stk_q[gi] <= 1'b0;
        end else if (exec_load && line_q && (int'(sp_q) == gi)) begin
          stk_q[gi] <= cond_q;
        end
      end
    end
  endgenerate

  // bit area address and output writes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      bit_addr_q <= 12'h000;
      bit_we_q <= 1'b0;
      bit_wd_q <= 1'b0;
    end else begin
      bit_we_q <= 1'b0;
      if ((state_q == lbx_pkg::S_DECODE) && (is_cond || is_out)) begin
        bit_addr_q <= opnd;
      end
      if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_OUT)) begin
        bit_we_q <= 1'b1;
        bit_wd_q <= cond_q;
      end else if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_OUT_INV)) begin
        bit_we_q <= 1'b1;
        bit_wd_q <= ~cond_q;
      end
    end
  end

  // end of scan pulse and halt level
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      done_q <= (state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_END);
      if ((state_q == lbx_pkg::S_FIND_CHK) && (op != lbx_pkg::OP_END) && wrap) begin
        halt_q <= 1'b1;
      end
    end
  end

  // sticky program faults, cleared only by reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      endc_q <= 1'b0;
    end else begin
      if (exec_load && line_q && (sp_q == lbx_pkg::SP_FULL)) begin
        ovf_q <= 1'b1;
      end
      if ((state_q == lbx_pkg::S_DECODE) && is_block && (sp_q == lbx_pkg::SP_EMPTY)) begin
        unf_q <= 1'b1;
      end
      if ((state_q == lbx_pkg::S_DECODE) && (op == lbx_pkg::OP_END) && line_q) begin
        endc_q <= 1'b1;
      end
    end
  end

  // port drive
  assign prog_addr = addr_q;
  assign prog_rd_en = (state_q == lbx_pkg::S_FIND) || (state_q == lbx_pkg::S_FETCH);
  assign bit_addr = bit_addr_q;
  assign bit_rd_en = (state_q == lbx_pkg::S_BITRD);
  assign bit_wr_en = bit_we_q;
  assign bit_wdata = bit_wd_q;
  assign exec_cond = cond_q;
  assign scan_done = done_q;
  assign running = (state_q == lbx_pkg::S_FETCH) || (state_q == lbx_pkg::S_DECODE) ||
                   (state_q == lbx_pkg::S_BITRD) || (state_q == lbx_pkg::S_EXEC);
  assign no_end_halt = halt_q;
  assign fault_overflow = ovf_q;
  assign fault_underflow = unf_q;
  assign fault_end_cond = endc_q;

endmodule : lbx_ladder_bit_logic_executor

// File: verification/lbx_mem_model.sv
// program memory and bit area model facing the executor
`timescale 1ns/1ps
module lbx_mem_model (
  // clock
  input wire logic sys_clk,
  // program memory side
  input wire logic [14:0] prog_addr,
  input wire logic prog_rd_en,
  output logic [15:0] prog_rdata,
  // bit area side
  input wire logic [11:0] bit_addr,
  input wire logic bit_rd_en,
  output logic bit_rdata,
  input wire logic bit_wr_en,
  input wire logic bit_wdata
);
  logic [15:0] prog [0:32767];
  logic bits [0:4095];
  // one cycle read latency; idle data flips so a stale value is never reused
  always @(posedge sys_clk) begin
    prog_rdata <= prog_rd_en ? prog[prog_addr] : ~prog_rdata;
    bit_rdata <= bit_rd_en ? bits[bit_addr] : ~bit_rdata;
    if (bit_wr_en) bits[bit_addr] <= bit_wdata;
  end
endmodule : lbx_mem_model

// File: verification/lbx_chk.sv
// port assertions for the executor
`timescale 1ns/1ps
module lbx_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // memory and bit area
  input wire logic [14:0] prog_addr,
  input wire logic prog_rd_en,
  input wire logic [15:0] prog_rdata,
  input wire logic bit_wr_en,
  input wire logic bit_wdata,
  // status
  input wire logic exec_cond,
  input wire logic scan_done,
  input wire logic running,
  input wire logic no_end_halt,
  input wire logic fault_overflow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // fetch and write behaviour
  a_start_at_zero: assert property ($rose(rst_b) |-> prog_rd_en && prog_addr == 15'h0000)
    else $error("fetch does not start at zero");
  a_out_value: assert property (bit_wr_en |-> bit_wdata ==
    (exec_cond ^ ($past(prog_rdata[15:12]) == lbx_pkg::OP_OUT_INV)))
    else $error("output bit value wrong");
  a_wr_one_pulse: assert property (bit_wr_en |=> !bit_wr_en)
    else $error("write longer than one cycle");
  a_wr_in_run: assert property (bit_wr_en |-> running)
    else $error("write outside a scan");
  // scan restart, halt and overflow flag
  a_scan_restart: assert property (scan_done |-> prog_addr == 15'h0000 && !exec_cond)
    else $error("scan does not restart clean");
  a_done_pulse: assert property (scan_done |=> !scan_done)
    else $error("scan done not a pulse");
  a_halt_quiet: assert property (no_end_halt |-> !running && !bit_wr_en && !scan_done)
    else $error("activity while halted");
  a_halt_sticky: assert property (no_end_halt |=> no_end_halt)
    else $error("halt released");
  a_ovf_sticky: assert property ($rose(fault_overflow) |=> fault_overflow [*4])
    else $error("overflow flag dropped");
endmodule : lbx_chk

bind lbx_ladder_bit_logic_executor lbx_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata),
  .bit_wr_en(bit_wr_en), .bit_wdata(bit_wdata), .exec_cond(exec_cond),
  .scan_done(scan_done), .running(running), .no_end_halt(no_end_halt),
  .fault_overflow(fault_overflow));

// File: verification/lbx_ladder_bit_logic_executor_tb_top.sv
// self-checking bench: executor against a reference scan model
`timescale 1ns/1ps
module lbx_ladder_bit_logic_executor_tb_top;
  logic sys_clk, rst_b, prog_rd_en, bit_rd_en, bit_wr_en, bit_wdata, bit_rdata;
  logic [14:0] prog_addr;
  logic [15:0] prog_rdata;
  logic [11:0] bit_addr;
  logic exec_cond, scan_done, running, no_end_halt, f_ovf, f_unf, f_endc;
  int fails = 0, n_tests = 0, seed = 6335, pa, n;
  logic [12:0] expq [$];
  logic mb [0:4095];
  logic [2:0] ef;
  lbx_ladder_bit_logic_executor u_lbx_ladder_bit_logic_executor (.sys_clk(sys_clk),
    .rst_b(rst_b), .prog_addr(prog_addr), .prog_rd_en(prog_rd_en), .prog_rdata(prog_rdata),
    .bit_addr(bit_addr), .bit_rd_en(bit_rd_en), .bit_rdata(bit_rdata), .bit_wr_en(bit_wr_en),
    .bit_wdata(bit_wdata), .exec_cond(exec_cond), .scan_done(scan_done), .running(running),
    .no_end_halt(no_end_halt), .fault_overflow(f_ovf), .fault_underflow(f_unf),
    .fault_end_cond(f_endc));
  lbx_mem_model u_mem (.sys_clk(sys_clk), .prog_addr(prog_addr), .prog_rd_en(prog_rd_en),
    .prog_rdata(prog_rdata), .bit_addr(bit_addr), .bit_rd_en(bit_rd_en),
    .bit_rdata(bit_rdata), .bit_wr_en(bit_wr_en), .bit_wdata(bit_wdata));
  // clock
  initial begin
    sys_clk = 0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  function automatic int rnd(int k);
    return ($random(seed) & 32'h7FFFFFFF) % k;
  endfunction : rnd
  function automatic void put(logic [15:0] w);
    u_mem.prog[pa] = w;
    pa++;
  endfunction : put
  // reference scan: stops at the first end, fills write list and fault bits
  function automatic void model();
    logic c = 0;
    logic o = 0;
    logic s;
    logic [15:0] w;
    logic st [$];
    for (int pc = 0; pc < 32768; pc++) begin
      w = u_mem.prog[pc];
      case (w[15:12])
        lbx_pkg::OP_LOAD, lbx_pkg::OP_LOAD_INV: begin
          if (o && st.size() == 7) ef[2] = 1;
          else if (o) st.push_back(c);
          c = mb[w[11:0]] ^ w[13];
          o = 1;
        end
        lbx_pkg::OP_AND, lbx_pkg::OP_AND_INV: begin
          c = c & (mb[w[11:0]] ^ w[14]);
          o = 1;
        end
        lbx_pkg::OP_OR, lbx_pkg::OP_OR_INV: begin
          c = c | (mb[w[11:0]] ^ w[13]);
          o = 1;
        end
        lbx_pkg::OP_BLOCK_AND, lbx_pkg::OP_BLOCK_OR: begin
          s = 0;
          if (st.size() == 0) ef[1] = 1;
          else s = st.pop_back();
          c = w[15] ? (c | s) : (c & s);
          o = 1;
        end
        lbx_pkg::OP_OUT, lbx_pkg::OP_OUT_INV: begin
          mb[w[11:0]] = c ^ w[13];
          expq.push_back({w[11:0], c ^ w[13]});
          o = 0;
        end
        lbx_pkg::OP_OTHER: pc += w[1:0];
        lbx_pkg::OP_END: begin
          if (o) ef[0] = 1;
          return;
        end
        default: ;
      endcase
    end
    // no end anywhere: nothing runs, so nothing is written
    expq.delete();
    ef = 0;
  endfunction : model
  // random program: t1 underflows, t2 overflows, t3 ends with an open line
  function automatic void gen(int t);
    int r, d;
    pa = 0;
    for (int l = 0; l < 8; l++) begin
      r = rnd(4);
      if (rnd(3) == 0) put({4'hE, 10'h000, r[1:0]});
      if (pa > 0 && u_mem.prog[pa - 1][15:12] == 4'hE) repeat (r) put(16'hF000);
      put({4'(1 + rnd(2)), 12'(rnd(32))});
      d = 0;
      repeat (t == 2 ? 12 : rnd(12)) begin
        r = rnd(8);
        if (r < (t == 2 ? 5 : 2)) begin
          put({4'(1 + rnd(2)), 12'(rnd(32))});
          d++;
        end else if (r == 2 && (d > 0 || t == 1)) begin
          put({4'(7 + rnd(2)), 12'h000});
          d--;
        end else put({4'(3 + rnd(4)), 12'(rnd(32))});
      end
      if (t != 3 || l < 7) repeat (1 + rnd(2)) put({4'(9 + rnd(2)), 12'(rnd(32))});
    end
    put(16'hF000);
    repeat (3) put({4'h9, 12'(rnd(32))});
  endfunction : gen
  task automatic do_reset();
    expq.delete();
    ef = 0;
    rst_b <= 1'b0;
    repeat (10) @(posedge sys_clk);
    model();
    rst_b <= 1'b1;
  endtask : do_reset
  // every output write is matched against the reference write list
  always @(posedge sys_clk) begin
    if (bit_wr_en === 1'b1) begin
      if (expq.size() > 0) check("write", {3'h0, bit_addr, bit_wdata}, {3'h0, expq.pop_front()});
      else check("extra write", 16'h0001, 16'h0000);
    end
  end
  // watchdog
  initial begin
    #(25 * 99000);
    fails++;
    report_and_stop();
  end
  initial begin
    for (int t = 0; t < 6; t++) begin
      gen(t);
      for (int i = 0; i < 4096; i++) u_mem.bits[i] = 1'(rnd(2));
      mb = u_mem.bits;
      do_reset();
      for (int s = 0; s < 2; s++) begin
        n = 0;
        do begin
          @(posedge sys_clk);
          n++;
        end while (scan_done !== 1'b1 && n < 3000);
        check("scan done", {15'h0, scan_done}, 16'h0001);
        @(posedge sys_clk);
        check("writes left", 16'(expq.size()), 16'h0000);
        check("faults", {13'h0, f_ovf, f_unf, f_endc}, {13'h0, ef});
        check("cond", {15'h0, exec_cond}, 16'h0000);
        model();
      end
      $display("test %0d done, mismatches %0d", t, fails);
    end
    // program without any end: search gives up, nothing runs
    for (int i = 0; i < 32768; i++) u_mem.prog[i] = 16'h0000;
    u_mem.prog[5] = 16'h9001;
    do_reset();
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (no_end_halt !== 1'b1 && n < 70000);
    repeat (20) @(posedge sys_clk);
    check("halt", {14'h0, no_end_halt, running}, 16'h0002);
    check("halt faults", {13'h0, f_ovf, f_unf, f_endc}, 16'h0000);
    $display("test no end done, mismatches %0d", fails);
    report_and_stop();
  end
endmodule : lbx_ladder_bit_logic_executor_tb_top
